// File: common/rmpm_pkg.sv
// Purpose: shared constants and types of the reset mode pin multiplexer
// Assumes: AXI4-Lite register bus, 32-bit data, byte addresses below
// Notes: all pin-facing enables are active high
package rmpm_pkg;
	localparam int unsigned RMPM_SYNC_STAGES = 2;
	localparam int unsigned RMPM_ADDR_W = 8;
	localparam int unsigned RMPM_N_INT = 6;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GPIO_DIR = 8'h04;
	localparam logic [7:0] REG_GPIO_OUT = 8'h08;
	localparam logic [7:0] REG_GPIO_IN = 8'h0C;
	localparam logic [7:0] REG_MODE = 8'h10;
	localparam logic [7:0] REG_INT_STATUS = 8'h14;
	localparam logic [7:0] REG_INT_MASK = 8'h18;
	localparam logic [7:0] REG_ALT_FLAG = 8'h1C;
	localparam logic [7:0] REG_VECTOR = 8'h20;

	// field positions
	localparam int unsigned CTRL_ALT_BIT = 0;
	localparam int unsigned CTRL_CFG_EDGE_BIT = 1;
	localparam int unsigned ALT_FLAG_OUT_BIT = 0;
	localparam int unsigned ALT_FLAG_IN_BIT = 1;
	localparam int unsigned STRAP_MODE_C_BIT = 2;
	localparam int unsigned STRAP_MODE_D_BIT = 3;
	localparam int unsigned MODE_HOST_BIT = 4;
	localparam int unsigned MODE_ACK_OD_BIT = 5;

	// interrupt status bit positions
	localparam int unsigned INT_EDGE = 0;
	localparam int unsigned INT_LEVEL_A = 1;
	localparam int unsigned INT_LEVEL_B = 2;
	localparam int unsigned INT_CONFIG = 3;
	localparam int unsigned INT_ALT0 = 4;
	localparam int unsigned INT_ALT1 = 5;

	// reset values
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [7:0] GPIO_DIR_RESET = 8'h00;
	localparam logic [7:0] GPIO_OUT_RESET = 8'hFF;
	localparam logic [5:0] INT_MASK_RESET = 6'h00;
	localparam logic ALT_FLAG_OUT_RESET = 1'b1;

	localparam logic BUS_MODE_FULL = 1'b0;
	localparam logic BUS_MODE_HOST = 1'b1;

	localparam logic [15:0] VEC_BASE = 16'h0004;
	localparam logic [15:0] VEC_STRIDE = 16'h0004;

	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef struct packed {
		logic ack_open_drain;
		logic host_mode;
		logic [3:0] straps;
	} rmpm_mode_t;

	typedef struct packed {
		logic cfg_edge;
		logic alt_en;
	} rmpm_ctrl_t;

	typedef struct packed {
		logic sclk;
		logic rx_fsync;
		logic tx_fsync;
		logic tx_data;
	} rmpm_sp_pins_t;
endpackage : rmpm_pkg

// File: rtl/rmpm_sync.sv
// Purpose: multi-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous to aclk
// Notes: no reset, so pins keep being sampled while aresetn is low
`timescale 1ns/1ps
module rmpm_sync #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned STAGES = 2
) (
	input wire logic aclk,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] chain [STAGES];

	// only the next stage reads each stage; the last stage drives dout
	genvar s;
	generate
		for (s = 0; s < STAGES; s++) begin : g_stage
			if (s == 0) begin : g_first
				always_ff @(posedge aclk) begin
					chain[0] <= din;
				end
			end else begin : g_rest
				always_ff @(posedge aclk) begin
					chain[s] <= chain[s-1];
				end
			end
		end
	endgenerate

	assign dout = chain[STAGES-1];
endmodule : rmpm_sync

// File: rtl/rmpm_top.sv
// Purpose: reset-mode pin multiplexer with strap capture, flag I/O,
//          shared interrupt detection and serial port b alternate role
// Assumes: one clock aclk, synchronous active-low aresetn
// Notes: pin outputs and enables are registered, one cycle behind core
//
// Overview of operation
// - bus pin function fixed by reset straps
// - serial b pins switchable any time
// - shared pins: interrupt and flag together
// - straps read in reset, flags afterwards
// - unmasked asserted pin raises its vector
// - flag output drive also raises interrupt
// - control register field picks serial role
// - strap C: 0 full memory, 1 host
// - full mode: 14 address, 24 data
// - host mode: 16-bit host address/data bus
// - strap D picks ack open drain
// - alternate: fsyncs interrupts, data flags
// - serial clock usable in alternate role
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module rmpm_top
	import rmpm_pkg::*;
#(
	parameter int unsigned ADDR_W = RMPM_ADDR_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	output logic [15:0] int_vector,
	output rmpm_mode_t mode,
	// shared bus pins
	input wire logic [13:0] addr_pin_i,
	output logic [13:0] addr_pin_o,
	output logic [13:0] addr_pin_oe,
	input wire logic [23:0] data_pin_i,
	output logic [23:0] data_pin_o,
	output logic [23:0] data_pin_oe,
	// flag pins, bits 3..0 double as mode straps
	input wire logic [7:0] gpio_i,
	output logic [7:0] gpio_o,
	output logic [7:0] gpio_oe,
	// serial port b pins
	input wire rmpm_sp_pins_t serial_b_i,
	input wire logic serial_b_rx_data,
	output rmpm_sp_pins_t serial_b_o,
	output rmpm_sp_pins_t serial_b_oe,
	// core side, full memory personality
	input wire logic [13:0] ext_addr_bus,
	input wire logic ext_addr_oe,
	input wire logic [23:0] ext_data_out,
	input wire logic ext_data_oe,
	output logic [23:0] ext_data_bus,
	// core side, host personality
	input wire logic [15:0] host_ad_out,
	input wire logic host_ad_oe,
	input wire logic host_ack_n,
	output logic [15:0] host_addr_data_bus,
	output logic host_write_en_n,
	output logic host_read_en_n,
	output logic host_addr_latch,
	output logic host_select_n,
	// core side, serial port b
	input wire rmpm_sp_pins_t serial_b_core_o,
	input wire rmpm_sp_pins_t serial_b_core_oe,
	output rmpm_sp_pins_t serial_b_core_i,
	output logic serial_b_core_rx_data
);
	localparam int unsigned SYNC_W = 14 + 24 + 8 + 5;

	logic [SYNC_W-1:0] sync_out;
	logic [13:0] addr_s;
	logic [23:0] data_s;
	logic [7:0] gpio_s;
	rmpm_sp_pins_t sp_s;
	logic dr_s;

	rmpm_ctrl_t ctrl;
	logic [7:0] gpio_dir;
	logic [7:0] gpio_out;
	logic [5:0] int_status;
	logic [5:0] int_mask;
	logic alt_flag_out;

	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic w_lane0;
	logic do_write;
	logic rd_take;
	logic wr_hit;
	logic [31:0] rd_val;
	logic rd_hit;

	logic [5:0] int_lvl;
	logic [5:0] int_lvl_q;
	logic [5:0] int_edge_sel;
	logic [5:0] int_set;
	logic [5:0] int_clr;
	logic [7:0] flag_level;
	logic [15:0] next_vector;

	logic [13:0] next_addr_o;
	logic [13:0] next_addr_oe;
	logic [23:0] next_data_o;
	logic [23:0] next_data_oe;
	rmpm_sp_pins_t next_sp_o;
	rmpm_sp_pins_t next_sp_oe;

	rmpm_sync #(
		.WIDTH(SYNC_W),
		.STAGES(RMPM_SYNC_STAGES)
	) u_sync (
		.aclk(aclk),
		.din({addr_pin_i, data_pin_i, gpio_i, serial_b_i, serial_b_rx_data}),
		.dout(sync_out)
	);

	assign {addr_s, data_s, gpio_s, sp_s, dr_s} = sync_out;

	// straps follow the pins for as long as reset is held, so the value
	// kept is the one seen at the release edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode.straps <= gpio_s[3:0];
			mode.host_mode <= gpio_s[STRAP_MODE_C_BIT];
			mode.ack_open_drain <= gpio_s[STRAP_MODE_D_BIT];
		end
	end

	// register bus: write channel
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign do_write = aw_held && w_held;

	always_comb begin
		wr_hit = 1'b0;
		unique case ({aw_addr_q[7:2], 2'b00})
			REG_CTRL, REG_GPIO_DIR, REG_GPIO_OUT, REG_GPIO_IN, REG_MODE,
			REG_INT_STATUS, REG_INT_MASK, REG_ALT_FLAG,
			REG_VECTOR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= 32'h0000_0000;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// writable registers; all fields sit in byte lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RESET;
			gpio_dir <= GPIO_DIR_RESET;
			gpio_out <= GPIO_OUT_RESET;
			int_mask <= INT_MASK_RESET;
			alt_flag_out <= ALT_FLAG_OUT_RESET;
		end else if (do_write && w_lane0) begin
			unique case ({aw_addr_q[7:2], 2'b00})
				REG_CTRL: ctrl <= w_data_q[1:0];
				REG_GPIO_DIR: gpio_dir <= w_data_q[7:0];
				REG_GPIO_OUT: gpio_out <= w_data_q[7:0];
				REG_INT_MASK: int_mask <= w_data_q[5:0];
				REG_ALT_FLAG: alt_flag_out <= w_data_q[ALT_FLAG_OUT_BIT];
				default: ;
			endcase
		end
	end

	// register bus: read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_take = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			REG_CTRL: rd_val[1:0] = ctrl;
			REG_GPIO_DIR: rd_val[7:0] = gpio_dir;
			REG_GPIO_OUT: rd_val[7:0] = gpio_out;
			REG_GPIO_IN: rd_val[7:0] = gpio_s;
			REG_MODE: rd_val[5:0] = mode;
			REG_INT_STATUS: rd_val[5:0] = int_status;
			REG_INT_MASK: rd_val[5:0] = int_mask;
			REG_ALT_FLAG: begin
				rd_val[ALT_FLAG_OUT_BIT] = alt_flag_out;
				rd_val[ALT_FLAG_IN_BIT] = dr_s;
			end
			REG_VECTOR: rd_val[15:0] = int_vector;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AXI_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// interrupt detection reads the level the pin carries, even when this
	// block drives it as a flag output; inputs are active low
	assign flag_level = (gpio_dir & gpio_out) | (~gpio_dir & gpio_s);
	assign int_lvl[3:0] = ~flag_level[7:4];
	assign int_lvl[INT_ALT0] = ctrl.alt_en && !sp_s.rx_fsync;
	assign int_lvl[INT_ALT1] = ctrl.alt_en && !sp_s.tx_fsync;
	assign int_edge_sel = {2'b11, ctrl.cfg_edge, 2'b00, 1'b1};
	assign int_set = (int_edge_sel & int_lvl & ~int_lvl_q)
		| (~int_edge_sel & int_lvl);
	assign int_clr = (rd_take && {s_axi_araddr[7:2], 2'b00} == REG_INT_STATUS)
		? int_status : 6'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_lvl_q <= 6'h00;
			int_status <= 6'h00;
		end else begin
			int_lvl_q <= int_lvl;
			// a new event in the clearing cycle survives the read
			int_status <= (int_status & ~int_clr) | int_set;
		end
	end

	// lowest index pending and unmasked wins the vector
	always_comb begin
		next_vector = 16'h0000;
		for (int i = RMPM_N_INT - 1; i >= 0; i--) begin
			if (int_status[i] && int_mask[i]) begin
				next_vector = VEC_BASE + 16'(i) * VEC_STRIDE;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
			int_vector <= 16'h0000;
		end else begin
			irq <= |(int_status & int_mask);
			int_vector <= next_vector;
		end
	end

	// flag pins: direction and value straight from registers
	assign gpio_o = gpio_out;
	assign gpio_oe = gpio_dir;

	// bus pin personality
	always_comb begin
		next_addr_o = ext_addr_bus;
		next_addr_oe = {14{ext_addr_oe}};
		next_data_o = ext_data_out;
		next_data_oe = {24{ext_data_oe}};
		if (mode.host_mode == BUS_MODE_HOST) begin
			next_addr_o[13:1] = host_ad_out[12:0];
			next_addr_oe[13:1] = {13{host_ad_oe}};
			next_data_o[7:0] = {5'h00, host_ad_out[15:13]};
			next_data_oe[7:0] = {5'h00, {3{host_ad_oe}}};
			// strap D high: pull low only, otherwise drive both levels
			if (mode.ack_open_drain) begin
				next_data_o[3] = 1'b0;
				next_data_oe[3] = !host_ack_n;
			end else begin
				next_data_o[3] = host_ack_n;
				next_data_oe[3] = 1'b1;
			end
		end
	end

	// serial port b: clock always the core's, even in the alternate role
	always_comb begin
		next_sp_o = serial_b_core_o;
		next_sp_oe = serial_b_core_oe;
		if (ctrl.alt_en) begin
			next_sp_o.rx_fsync = 1'b0;
			next_sp_oe.rx_fsync = 1'b0;
			next_sp_o.tx_fsync = 1'b0;
			next_sp_oe.tx_fsync = 1'b0;
			next_sp_o.tx_data = alt_flag_out;
			next_sp_oe.tx_data = 1'b1;
		end
	end

	// pins float during reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_pin_o <= 14'h0000;
			addr_pin_oe <= 14'h0000;
			data_pin_o <= 24'h00_0000;
			data_pin_oe <= 24'h00_0000;
			serial_b_o <= '0;
			serial_b_oe <= '0;
		end else begin
			addr_pin_o <= next_addr_o;
			addr_pin_oe <= next_addr_oe;
			data_pin_o <= next_data_o;
			data_pin_oe <= next_data_oe;
			serial_b_o <= next_sp_o;
			serial_b_oe <= next_sp_oe;
		end
	end

	// core-facing inputs; host controls idle outside host mode
	assign ext_data_bus = data_s;
	assign host_addr_data_bus = {data_s[2:0], addr_s[13:1]};
	assign host_write_en_n = mode.host_mode ? data_s[7] : 1'b1;
	assign host_read_en_n = mode.host_mode ? data_s[6] : 1'b1;
	assign host_addr_latch = mode.host_mode ? data_s[5] : 1'b0;
	assign host_select_n = mode.host_mode ? data_s[4] : 1'b1;
	assign serial_b_core_i = ctrl.alt_en
		? {sp_s.sclk, 3'b000}
		: sp_s;
	assign serial_b_core_rx_data = ctrl.alt_en ? 1'b0 : dr_s;
endmodule : rmpm_top

// File: test/rmpm_pin_partner.sv
// Purpose: board and far-side devices on the multiplexed pins
// Assumes: far values come from the bench, pins resolve per bit
// Notes: an enabled design driver always wins over the far side
`timescale 1ns/1ps
module rmpm_pin_partner
	import rmpm_pkg::*;
(
	input wire logic [7:0] far_gpio,
	input wire rmpm_sp_pins_t far_sp,
	input wire logic far_rx,
	input wire logic [23:0] far_data,
	input wire logic [13:0] far_addr,
	input wire logic [7:0] gpio_o,
	input wire logic [7:0] gpio_oe,
	output logic [7:0] gpio_i,
	input wire rmpm_sp_pins_t serial_b_o,
	input wire rmpm_sp_pins_t serial_b_oe,
	output rmpm_sp_pins_t serial_b_i,
	output logic serial_b_rx_data,
	input wire logic [23:0] data_pin_o,
	input wire logic [23:0] data_pin_oe,
	output logic [23:0] data_pin_i,
	input wire logic [13:0] addr_pin_o,
	input wire logic [13:0] addr_pin_oe,
	output logic [13:0] addr_pin_i
);
	// board holds straps steady across reset, flag lines pulled high
	assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & far_gpio);
	assign serial_b_i = (serial_b_oe & serial_b_o) | (~serial_b_oe & far_sp);
	assign serial_b_rx_data = far_rx;
	// host drives its controls and address/data; open-drain ack pulls low
	assign data_pin_i = (data_pin_oe & data_pin_o) | (~data_pin_oe & far_data);
	assign addr_pin_i = (addr_pin_oe & addr_pin_o) | (~addr_pin_oe & far_addr);
endmodule : rmpm_pin_partner

// File: test/rmpm_top_monitor.sv
// Purpose: port-level checker for rmpm_top
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached by the bind after the module
`timescale 1ns/1ps
module rmpm_monitor
	import rmpm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic irq,
	input wire logic [15:0] int_vector,
	input wire rmpm_mode_t mode,
	input wire logic [7:0] gpio_i,
	input wire logic [13:0] addr_pin_i,
	input wire logic [13:0] addr_pin_o,
	input wire logic [13:0] addr_pin_oe,
	input wire logic [23:0] data_pin_i,
	input wire logic [23:0] ext_data_bus,
	input wire logic [13:0] ext_addr_bus,
	input wire logic ext_addr_oe,
	input wire logic [15:0] host_addr_data_bus,
	input wire logic host_write_en_n,
	input wire logic host_read_en_n,
	input wire logic host_addr_latch,
	input wire logic host_select_n
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_mode_frozen: assert property ($past(aresetn) |-> $stable(mode))
		else $error("mode moved outside reset");
	// two sync stages plus the capture edge sit between pin and mode
	a_strap_capture: assert property (!$past(aresetn) |->
		mode.straps == $past(gpio_i[3:0], 3))
		else $error("straps not taken from the pins at release");
	a_host_strap: assert property (mode.host_mode == mode.straps[2])
		else $error("bus personality differs from strap");
	a_ack_strap: assert property (mode.ack_open_drain == mode.straps[3])
		else $error("ack drive style differs from strap");
	a_vector_irq: assert property (irq == (int_vector != 16'h0000))
		else $error("vector and irq disagree");
	a_host_idle: assert property (!mode.host_mode |-> {host_write_en_n,
		host_read_en_n, host_addr_latch, host_select_n} == 4'hD)
		else $error("host controls active in full mode");
	a_host_map: assert property (mode.host_mode |-> host_addr_data_bus ==
		$past({data_pin_i[2:0], addr_pin_i[13:1]}, 2))
		else $error("host address/data mapping wrong");
	a_full_data: assert property (!mode.host_mode |->
		ext_data_bus == $past(data_pin_i, 2))
		else $error("data pins not passed to core");
	a_addr_drive: assert property (!mode.host_mode && $past(ext_addr_oe) &&
		$past(aresetn) |-> addr_pin_oe == 14'h3FFF &&
		addr_pin_o == $past(ext_addr_bus))
		else $error("address pins not driven from core");

	c_irq: cover property (irq);
	c_host: cover property (mode.host_mode);
	c_full_drive: cover property (!mode.host_mode && ext_addr_oe);
endmodule : rmpm_monitor

bind rmpm_top rmpm_monitor mon_u (.*);

// File: test/rmpm_top_tb_top.sv
// Purpose: self-checking bench for rmpm_top
// Assumes: AXI4-Lite master tasks, far side from rmpm_pin_partner
// Notes: runs a host-mode boot, then a full-mode boot
`timescale 1ns/1ps
module rmpm_top_tb_top
	import rmpm_pkg::*;
;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] w;
		logic [31:0] r;
		logic [1:0] resp;
	} rmpm_row_t;
	logic aclk, aresetn, irq, far_rx, ext_addr_oe, ext_data_oe;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, host_ad_oe, host_ack_n;
	logic host_write_en_n, host_read_en_n, host_addr_latch, host_select_n;
	logic serial_b_rx_data, serial_b_core_rx_data;
	logic [7:0] s_axi_awaddr, s_axi_araddr, gpio_i, gpio_o, gpio_oe, far_gpio;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
	logic [15:0] int_vector, host_ad_out, host_addr_data_bus;
	logic [13:0] addr_pin_i, addr_pin_o, addr_pin_oe, ext_addr_bus, far_addr;
	logic [23:0] data_pin_i, data_pin_o, data_pin_oe, ext_data_out;
	logic [23:0] ext_data_bus, far_data;
	rmpm_mode_t mode;
	rmpm_sp_pins_t serial_b_i, serial_b_o, serial_b_oe, serial_b_core_o;
	rmpm_sp_pins_t serial_b_core_oe, serial_b_core_i, far_sp;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	rmpm_row_t rows [10] = '{
		'{1'b0, REG_CTRL, 32'h0, 32'h0, AXI_OKAY},
		'{1'b0, REG_GPIO_DIR, 32'h0, 32'h0, AXI_OKAY},
		'{1'b0, REG_GPIO_OUT, 32'h0, 32'hFF, AXI_OKAY},
		'{1'b0, REG_INT_MASK, 32'h0, 32'h0, AXI_OKAY},
		'{1'b1, REG_CTRL, 32'h2, 32'h2, AXI_OKAY},
		'{1'b1, REG_GPIO_DIR, 32'hF0, 32'hF0, AXI_OKAY},
		'{1'b1, REG_GPIO_OUT, 32'h5A, 32'h5A, AXI_OKAY},
		'{1'b1, REG_INT_MASK, 32'h3F, 32'h3F, AXI_OKAY},
		'{1'b1, REG_MODE, 32'h0, 32'h3C, AXI_OKAY},
		'{1'b1, 8'h40, 32'h1, 32'h0, AXI_SLVERR}
	};

	rmpm_top dut_u (.*);
	rmpm_pin_partner far_u (.*);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic give_verdict;
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	// a hung handshake would otherwise stall the run forever
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic waitc(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : waitc

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		br = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a);
		check(rd, e);
	endtask : rd_chk

	// straps must sit on the pins for several edges before release
	task automatic do_reset(input logic [3:0] s);
		@(posedge aclk);
		aresetn <= 1'b0;
		far_gpio <= {4'hF, s};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
	endtask : do_reset

	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, ext_addr_oe, ext_data_oe, host_ad_oe} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{far_data, ext_data_out, far_addr, ext_addr_bus} = 76'h0;
		{host_ad_out, serial_b_core_o, serial_b_core_oe} = 24'h0;
		s_axi_wstrb = 4'hF;
		host_ack_n = 1'b1;
		far_rx = 1'b1;
		far_sp = 4'h6;
		do_reset(4'hC);
		check(32'(mode), 32'h3C);
		@(posedge aclk);
		far_gpio <= 8'hF3;
		far_data <= 24'h000065;
		far_addr <= 14'h2468;
		host_ack_n <= 1'b0;
		waitc(4);
		check(32'(mode), 32'h3C);
		check(32'(host_addr_data_bus), 32'hB234);
		check(32'({host_write_en_n, host_read_en_n, host_addr_latch,
			host_select_n}), 32'h6);
		check(32'({data_pin_oe[3], data_pin_o[3]}), 32'h2);
		rd_chk(REG_GPIO_IN, 32'hF3);
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				axi_wr(rows[i].a, rows[i].w);
				check(32'(br), 32'(rows[i].resp));
			end
			axi_rd(rows[i].a);
			check(32'(rr), 32'(rows[i].resp));
			if (rows[i].resp === AXI_OKAY) check(rd, rows[i].r);
		end
		check(32'({gpio_oe, gpio_o}), 32'hF05A);
		waitc(4);
		check(32'(int_vector), 32'h8);
		rd_chk(REG_INT_STATUS, 32'hA);
		axi_wr(REG_GPIO_OUT, 32'hFF);
		axi_wr(REG_GPIO_DIR, 32'h0);
		axi_wr(REG_INT_MASK, 32'h0);
		axi_rd(REG_INT_STATUS);
		rd_chk(REG_INT_STATUS, 32'h0);
		far_gpio <= 8'hE3;
		host_ack_n <= 1'b1;
		waitc(5);
		check(32'(irq), 32'h0);
		rd_chk(REG_GPIO_IN, 32'hE3);
		axi_wr(REG_INT_MASK, 32'h1);
		waitc(3);
		check(32'(int_vector), 32'h4);
		@(posedge aclk);
		far_gpio <= 8'hF3;
		rd_chk(REG_INT_STATUS, 32'h1);
		waitc(3);
		check(32'(irq), 32'h0);
		check(32'(serial_b_core_rx_data), 32'h1);
		axi_wr(REG_CTRL, 32'h1);
		axi_wr(REG_ALT_FLAG, 32'h0);
		far_sp <= 4'hE;
		waitc(4);
		check(32'(serial_b_core_rx_data), 32'h0);
		check(32'(serial_b_core_i), 32'h8);
		check(32'({serial_b_oe.tx_data, serial_b_o.tx_data}), 32'h2);
		rd_chk(REG_ALT_FLAG, 32'h2);
		axi_wr(REG_INT_MASK, 32'h30);
		far_sp <= 4'hA;
		waitc(5);
		check(32'(int_vector), 32'h14);
		@(posedge aclk);
		far_sp <= 4'hC;
		waitc(5);
		@(posedge aclk);
		far_sp <= 4'hE;
		rd_chk(REG_INT_STATUS, 32'h30);
		axi_wr(REG_CTRL, 32'h0);
		waitc(3);
		check(32'(serial_b_core_rx_data), 32'h1);
		do_reset(4'h3);
		check(32'(mode), 32'h03);
		rd_chk(REG_CTRL, 32'h0);
		@(posedge aclk);
		ext_addr_bus <= 14'h1ABC;
		ext_addr_oe <= 1'b1;
		far_data <= 24'hA5C3F0;
		waitc(3);
		check(32'(addr_pin_o), 32'h1ABC);
		check(32'(ext_data_bus), 32'hA5C3F0);
		@(posedge aclk);
		ext_data_out <= 24'h13579B;
		ext_data_oe <= 1'b1;
		waitc(2);
		check(32'(data_pin_o), 32'h13579B);
		// a write without lane 0 must leave the flag outputs alone
		s_axi_wstrb <= 4'hE;
		axi_wr(REG_GPIO_OUT, 32'h00);
		check(32'(br), 32'(AXI_OKAY));
		rd_chk(REG_GPIO_OUT, 32'hFF);
		give_verdict();
	end
endmodule : rmpm_top_tb_top
